// File: logic/tms_map.svh
`ifndef TMS_MAP_SVH
`define TMS_MAP_SVH
`define TMS_DRIVE_LINES    8
`define TMS_SENSE_LINES    6
`define TMS_KEY_POSITIONS  48
`define TMS_MAX_BURST      7'h40
`define TMS_DEF_MAX_KEYS   48
`define TMS_PULSE_CYCLES   4
`define TMS_SPI_IDLE_SCK   1'b0
`define TMS_UART_IDLE_RX   1'b1
`define TMS_CLK_MHZ        100
`define TMS_BAUD           57600
`define TMS_BIT_CYCLES     ((`TMS_CLK_MHZ * 1000000) / `TMS_BAUD)
`endif

// File: logic/tms_pkg.sv
`include "tms_map.svh"
package tms_pkg;
   typedef enum logic [2:0] {
      TMS_IDLE,
      TMS_SEEK,
      TMS_BURST,
      TMS_CONVERT,
      TMS_WAIT
   } tms_state_t;

   typedef enum logic [1:0] {
      TMS_PORT_NONE,
      TMS_PORT_SPI,
      TMS_PORT_UART
   } tms_port_t;

   typedef struct packed {
      logic [2:0] drive;
      logic [2:0] sense;
   } tms_pos_t;

   typedef struct packed {
      logic       valid;
      tms_pos_t   pos;
      logic [6:0] pulses;
   } tms_result_t;

   typedef struct packed {
      logic       we;
      logic [5:0] index;
      logic [6:0] length;
   } tms_cfg_wr_t;
endpackage : tms_pkg

// File: logic/tms_burst_mem.sv
`timescale 1ns/1ns
`include "tms_map.svh"
module tms_burst_mem #(
   parameter int DEPTH = `TMS_KEY_POSITIONS
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire tms_pkg::tms_cfg_wr_t wr,
   input  wire logic [5:0]       rd_index,
   output logic [6:0]            rd_length
);
   import tms_pkg::*;

   logic [6:0] mem [DEPTH];

   // Memory held in reset so every key starts at full burst length
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= `TMS_MAX_BURST;
         end
         rd_length <= 7'h00;
      end else begin
         if (wr.we && (int'(wr.index) < DEPTH)) begin
            mem[wr.index] <= (wr.length > `TMS_MAX_BURST) ? `TMS_MAX_BURST : wr.length;
         end
         rd_length <= (int'(rd_index) < DEPTH) ? mem[rd_index] : 7'h00;
      end
   end
endmodule : tms_burst_mem

// File: logic/tms_scan_seq.sv
`timescale 1ns/1ns
`include "tms_map.svh"
// Contract
// - Every round begins at drive line zero, sense line zero.
// - Visit all drive lines ascending for each sense line, sense lines ascending.
// - Any of 8 drive by 6 sense positions is addressable by one index.
// - Burst of up to 64 pulses, length from that key's own setting.
// - Burst finishes before next; then result converted and handed on.
// - Disabled keys take no timeslot in the round.
// - Maximum key count 16, 24, 32 or 48; never enable beyond it.
// - Detect host port, SPI or UART, from line activity without strap.
// - Host sends single-byte commands; device answers single bytes mostly. No command interface is built here.
module tms_scan_seq #(
   parameter int MAX_KEYS     = `TMS_DEF_MAX_KEYS,
   parameter int PULSE_CYCLES = `TMS_PULSE_CYCLES
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 scan_run,
   input  wire logic [47:0]          key_enable_req,
   input  wire tms_pkg::tms_cfg_wr_t cfg_wr,
   input  wire logic                 spi_sck,
   input  wire logic                 uart_rx,
   input  wire logic                 convert_done,
   input  wire logic [9:0]           convert_value,
   output logic [7:0]                drive_lines,
   output logic [5:0]                sense_sel,
   output logic                      pulse,
   output logic                      convert_start,
   output tms_pkg::tms_result_t      result,
   output logic [9:0]                result_value,
   output logic                      round_done,
   output tms_pkg::tms_port_t        host_port,
   output logic [5:0]                enabled_count
);
   import tms_pkg::*;

   typedef struct packed {
      tms_state_t  state;
      logic [5:0]  index;
      logic [6:0]  pulses;
      logic [6:0]  target;
      logic [3:0]  phase;
      logic [47:0] enable;
      logic [7:0]  drive_lines;
      logic [5:0]  sense_sel;
      logic        pulse;
      logic        convert_start;
      tms_result_t result;
      logic [9:0]  result_value;
      logic        round_done;
      tms_port_t   host_port;
      logic [5:0]  enabled_count;
   } tms_scan_t;

   tms_scan_t cur;
   tms_scan_t next_cur;
   logic [6:0] burst_len;
   logic [47:0] granted;

   // Index is sense-major: index = sense * 8 + drive
   function automatic tms_pos_t pos_of(input logic [5:0] idx);
      tms_pos_t p;
      p.drive = idx[2:0];
      p.sense = idx[5:3];
      return p;
   endfunction : pos_of

   // Shift amounts stay inside the grid, so no out-of-range select
   function automatic logic [7:0] drive_onehot(input logic [5:0] idx);
      return 8'h01 << idx[2:0];
   endfunction : drive_onehot

   function automatic logic [5:0] sense_onehot(input logic [5:0] idx);
      return 6'h01 << idx[5:3];
   endfunction : sense_onehot

   function automatic logic is_last(input logic [5:0] idx);
      return idx == 6'(`TMS_KEY_POSITIONS - 1);
   endfunction : is_last

   // Keep only the lowest MAX_KEYS requested keys; extras are refused
   function automatic logic [47:0] limit_enable(input logic [47:0] req);
      logic [47:0] out;
      int          n;
      out = 48'h0;
      n = 0;
      for (int i = 0; i < `TMS_KEY_POSITIONS; i++) begin
         if (req[i] && (n < MAX_KEYS)) begin
            out[i] = 1'b1;
            n = n + 1;
         end
      end
      return out;
   endfunction : limit_enable

   function automatic logic [5:0] count_ones(input logic [47:0] v);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < `TMS_KEY_POSITIONS; i++) begin
         c = c + {5'h00, v[i]};
      end
      return c;
   endfunction : count_ones

   // Grant computed once so the mask and its count always agree
   assign granted = limit_enable(key_enable_req);

   tms_burst_mem #(
      .DEPTH(`TMS_KEY_POSITIONS)
   ) u_mem (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .wr        (cfg_wr),
      .rd_index  (cur.index),
      .rd_length (burst_len)
   );

   always_comb begin
      next_cur = cur;
      next_cur.convert_start = 1'b0;
      next_cur.round_done = 1'b0;
      next_cur.result.valid = 1'b0;
      // Port choice latches on first departure from idle level
      if (cur.host_port == TMS_PORT_NONE) begin
         if (spi_sck != `TMS_SPI_IDLE_SCK) begin
            next_cur.host_port = TMS_PORT_SPI;
         end else if (uart_rx != `TMS_UART_IDLE_RX) begin
            next_cur.host_port = TMS_PORT_UART;
         end
      end
      unique case (cur.state)
         TMS_IDLE: begin
            next_cur.drive_lines = 8'h00;
            next_cur.pulse = 1'b0;
            if (scan_run) begin
               // Enable set sampled only at round start so a round is coherent
               next_cur.enable = granted;
               next_cur.enabled_count = count_ones(granted);
               next_cur.index = 6'h00;
               next_cur.state = TMS_SEEK;
            end
         end
         TMS_SEEK: begin
            if (cur.enable[cur.index]) begin
               next_cur.state = TMS_WAIT;
            end else if (is_last(cur.index)) begin
               next_cur.round_done = 1'b1;
               next_cur.state = TMS_IDLE;
            end else begin
               next_cur.index = cur.index + 6'h01;
            end
         end
         TMS_WAIT: begin
            // One cycle for the burst-length memory read to land
            next_cur.target = (burst_len == 7'h00) ? 7'h01 : burst_len;
            next_cur.pulses = 7'h00;
            next_cur.phase = 4'h0;
            next_cur.sense_sel = sense_onehot(cur.index);
            next_cur.state = TMS_BURST;
         end
         TMS_BURST: begin
            next_cur.phase = cur.phase + 4'h1;
            if (cur.phase == 4'(PULSE_CYCLES - 1)) begin
               next_cur.phase = 4'h0;
               next_cur.pulse = ~cur.pulse;
               next_cur.drive_lines = cur.pulse ? 8'h00 : drive_onehot(cur.index);
               if (cur.pulse) begin
                  next_cur.pulses = cur.pulses + 7'h01;
                  if (cur.pulses + 7'h01 == cur.target) begin
                     next_cur.convert_start = 1'b1;
                     next_cur.state = TMS_CONVERT;
                  end
               end
            end
         end
         TMS_CONVERT: begin
            if (convert_done) begin
               next_cur.result.valid = 1'b1;
               next_cur.result.pos = pos_of(cur.index);
               next_cur.result.pulses = cur.pulses;
               next_cur.result_value = convert_value;
               // Sense line released so the next key starts from a quiet matrix
               next_cur.sense_sel = 6'h00;
               if (is_last(cur.index)) begin
                  next_cur.round_done = 1'b1;
                  next_cur.state = TMS_IDLE;
               end else begin
                  next_cur.index = cur.index + 6'h01;
                  next_cur.state = TMS_SEEK;
               end
            end
         end
         // Unused state codes fall back to idle
         default: begin
            next_cur.state = TMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // Burst-length memory returns to full length on its own reset
         cur <= '0;
         cur.state <= TMS_IDLE;
         cur.host_port <= TMS_PORT_NONE;
      end else begin
         cur <= next_cur;
      end
   end

   assign drive_lines   = cur.drive_lines;
   assign sense_sel     = cur.sense_sel;
   assign pulse         = cur.pulse;
   assign convert_start = cur.convert_start;
   assign result        = cur.result;
   assign result_value  = cur.result_value;
   assign round_done    = cur.round_done;
   assign host_port     = cur.host_port;
   assign enabled_count = cur.enabled_count;
endmodule : tms_scan_seq

// File: verification/tms_chk_chk.sv
`timescale 1ns/1ns
module tms_chk
   import tms_pkg::*;
#(parameter int MAX_KEYS = 48) (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        scan_run,
   input wire logic [47:0] key_enable_req,
   input wire tms_cfg_wr_t cfg_wr,
   input wire logic        spi_sck,
   input wire logic        uart_rx,
   input wire logic        convert_done,
   input wire logic [9:0]  convert_value,
   input wire logic [7:0]  drive_lines,
   input wire logic [5:0]  sense_sel,
   input wire logic        pulse,
   input wire logic        convert_start,
   input wire tms_result_t result,
   input wire logic [9:0]  result_value,
   input wire logic        round_done,
   input wire tms_port_t   host_port,
   input wire logic [5:0]  enabled_count
);
   logic [5:0] last;
   logic       fresh;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // First result of a round has no predecessor to compare with
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         last <= 6'h00;
         fresh <= 1'b1;
      end else if (round_done) begin
         fresh <= 1'b1;
      end else if (result.valid) begin
         last <= {result.pos.sense, result.pos.drive};
         fresh <= 1'b0;
      end
   end
   drive_hot_a: assert property (pulse |-> $onehot(drive_lines) && $onehot(sense_sel))
      else $error("drive or sense not one-hot");
   drive_idle_a: assert property (!pulse |-> drive_lines == 8'h00)
      else $error("drive active outside pulse");
   key_order_a: assert property (result.valid && !fresh |->
      {result.pos.sense, result.pos.drive} > last) else $error("key order broken");
   burst_len_a: assert property (result.valid |-> result.pulses inside {[7'h01:7'h40]})
      else $error("burst length out of range");
   conv_quiet_a: assert property (convert_start |=> (!pulse)[*8])
      else $error("pulse during conversion");
   result_next_a: assert property (convert_done |=> result.valid)
      else $error("result not handed on");
   result_data_a: assert property (result.valid |-> result_value == $past(convert_value))
      else $error("result value wrong");
   key_cap_a: assert property (enabled_count <= MAX_KEYS)
      else $error("too many keys enabled");
   port_latch_a: assert property (host_port != TMS_PORT_NONE |=> $stable(host_port))
      else $error("host port changed");
   round_pulse_a: assert property (round_done |=> !round_done)
      else $error("round done too long");
   cover property (result.valid && fresh);
   cover property (round_done);
   cover property (host_port == TMS_PORT_UART);
   cover property (host_port == TMS_PORT_SPI);
endmodule : tms_chk
bind tms_scan_seq tms_chk #(.MAX_KEYS(MAX_KEYS)) u_chk (.mclk(mclk), .rst_n(rst_n),
   .scan_run(scan_run), .key_enable_req(key_enable_req), .cfg_wr(cfg_wr), .spi_sck(spi_sck),
   .uart_rx(uart_rx), .convert_done(convert_done), .convert_value(convert_value),
   .drive_lines(drive_lines), .sense_sel(sense_sel), .pulse(pulse),
   .convert_start(convert_start), .result(result), .result_value(result_value),
   .round_done(round_done), .host_port(host_port), .enabled_count(enabled_count));

// File: verification/tms_adc_model.sv
`timescale 1ns/1ns
module tms_adc_model (
   input wire logic  mclk,
   input wire logic  rst_n,
   input wire logic  convert_start,
   input wire logic  slow,
   output logic       convert_done,
   output logic [9:0] convert_value
);
   int n;
   // Value wanders every cycle, so only the done cycle carries meaning
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         n <= 0;
         convert_done <= 1'b0;
         convert_value <= 10'h000;
      end else begin
         n <= convert_start ? (slow ? 40 : 4) : (n != 0 ? n - 1 : 0);
         convert_done <= (n == 1);
         convert_value <= convert_value + 10'h25;
      end
   end
endmodule : tms_adc_model

// File: verification/tb_touch_matrix_scan_sequencer.sv
`timescale 1ns/1ns
module tb_touch_matrix_scan_sequencer;
   import tms_pkg::*;
   localparam int MK = 24;
   logic mclk = 1'b0, rst_n = 1'b0, scan_run = 1'b0, sck = 1'b0, rx = 1'b1, slow = 1'b0;
   logic cd, cs, pulse, rd, pq = 1'b0;
   logic [47:0] en = '0;
   logic [9:0] cv, rv, lastv;
   logic [7:0] dl;
   logic [5:0] ss, ec;
   logic [31:0] lf = 32'h4c9009be;
   tms_cfg_wr_t cfg = '0;
   tms_result_t res;
   tms_port_t hp;
   int n_fail = 0, tests_run = 0, npul = 0, ecnt = 0, q[$], bl[48];
   always #5 mclk = ~mclk;
   tms_scan_seq #(.MAX_KEYS(MK)) u_dut (.mclk(mclk), .rst_n(rst_n), .scan_run(scan_run),
      .key_enable_req(en), .cfg_wr(cfg), .spi_sck(sck), .uart_rx(rx), .convert_done(cd),
      .convert_value(cv), .drive_lines(dl), .sense_sel(ss), .pulse(pulse),
      .convert_start(cs), .result(res), .result_value(rv), .round_done(rd),
      .host_port(hp), .enabled_count(ec));
   tms_adc_model u_adc (.mclk(mclk), .rst_n(rst_n), .convert_start(cs), .slow(slow),
      .convert_done(cd), .convert_value(cv));
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nx
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      tests_run++;
      if (e !== s) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   // Lowest enabled indices fill the round, up to the key cap
   function automatic void fill();
      ecnt = 0;
      for (int i = 0; i < 48; i++) if (en[i] && ecnt < MK) begin
         q.push_back(i);
         ecnt++;
      end
   endfunction : fill
   always @(posedge mclk) begin
      if (cd) lastv = cv;
      if (pulse && !pq) begin
         if (q.size() == 0) fill();
         npul++;
         chk("drive", 16'(8'h01 << (q[0] % 8)), dl);
         chk("sense", 16'(6'h01 << (q[0] / 8)), ss);
      end
      if (cs) chk("start", 16'(bl[q[0]]), 16'(npul));
      if (res.valid) begin
         chk("pos", 16'(q[0]), {res.pos.sense, res.pos.drive});
         chk("pulses", 16'(bl[q[0]]), res.pulses);
         chk("burst", 16'(bl[q[0]]), 16'(npul));
         chk("value", lastv, rv);
         npul = 0;
         void'(q.pop_front());
      end
      if (rd) begin
         chk("left", 16'h0000, 16'(q.size()));
         chk("enabled", 16'(ecnt), ec);
      end
      pq = pulse;
   end
   task automatic wr(int i, int l);
      @(posedge mclk);
      cfg <= '{1'b1, 6'(i), 7'(l)};
      bl[i] = l > 64 ? 64 : (l == 0 ? 1 : l);
      @(posedge mclk);
      cfg <= '0;
   endtask : wr
   task automatic run(logic [47:0] e, int r);
      int k;
      en <= e;
      scan_run <= 1'b1;
      // Drop the run request once the last wanted round has left idle
      repeat (2) @(posedge mclk);
      for (int i = 1; i < r; i++) begin
         @(posedge mclk);
         while (!rd) @(posedge mclk);
      end
      scan_run <= 1'b0;
      k = 0;
      while (k < 80) begin
         @(posedge mclk);
         k = (ss == 6'h00 && !pulse) ? k + 1 : 0;
      end
      $display("test done, %0d compares", tests_run);
   endtask : run
   task automatic complete_run();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   initial begin
      #600000;
      n_fail++;
      complete_run();
   end
   initial begin
      foreach (bl[i]) bl[i] = 64;
      repeat (20) @(posedge mclk);
      chk("reset", 16'h0000, {dl, ss, hp});
      rst_n <= 1'b1;
      run(48'h8000_0000_0013, 2);
      for (int i = 0; i < 48; i++) begin
         lf = nx(lf);
         wr(i, lf % 100);
      end
      wr(0, 0);
      wr(1, 65);
      slow <= 1'b1;
      run(48'({nx(lf), lf}) | 48'h1, 2);
      slow <= 1'b0;
      run(48'hffff_ffff_ffff, 1);
      rx <= 1'b0;
      repeat (4) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("port", 16'(TMS_PORT_UART), 16'(hp));
      $display("port test done, %0d compares", tests_run);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("reset", 16'h0000, {dl, ss, hp});
      foreach (bl[i]) bl[i] = 64;
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("port", 16'(TMS_PORT_SPI), 16'(hp));
      run(48'h0000_0000_0001, 1);
      complete_run();
   end
endmodule : tb_touch_matrix_scan_sequencer
